// [hw/pss_pkg.sv]
/*
  Constants for the preset step sequencer: register offsets, field positions,
  reset values, condition and destination codes, timing counts.
  Assumes a 100 MHz system clock.
*/
package pss_pkg;
  localparam int          NUM_STEPS      = 8;
  localparam int          FREQ_W         = 16;
  localparam int          DWELL_W        = 14;
  // ******************************************************************
  // register map (word indices on the plain register port)
  // ******************************************************************
  localparam logic [7:0]  OFF_PROG_BASE  = 8'h00;
  localparam logic [7:0]  OFF_DWELL_BASE = 8'h08;
  localparam logic [7:0]  OFF_FREQ_BASE  = 8'h10;
  localparam logic [7:0]  OFF_CTRL       = 8'h18;
  localparam logic [7:0]  OFF_STATUS     = 8'h19;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h1A;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h1B;
  localparam logic [7:0]  OFF_OUT_SEL    = 8'h1C;
  localparam logic [15:0] PROG_RESET     = 16'h00F1;
  localparam logic [13:0] DWELL_RESET    = 14'h012C;
  localparam logic [13:0] DWELL_MAX      = 14'h270F;
  localparam logic [15:0] FREQ_RESET     = 16'h0000;
  // ******************************************************************
  // control register fields
  // ******************************************************************
  localparam int          CTRL_SRC_LSB   = 0;
  localparam int          CTRL_DI0_LSB   = 4;
  // relay select lsb in the output select word, opto selects follow
  localparam int          CTRL_RLY_LSB   = 0;
  localparam int          SEL_W          = 5;
  localparam logic [3:0]  SRC_SEQUENCER  = 4'h6;
  localparam logic [4:0]  DI_SEL_IN_A    = 5'h17;
  localparam logic [4:0]  DI_SEL_IN_B    = 5'h18;
  localparam logic [4:0]  OUT_SEL_SHARED = 5'h0F;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  // ******************************************************************
  // program word digits
  // ******************************************************************
  localparam logic [3:0]  COND_NEVER     = 4'hF;
  localparam logic [3:0]  DEST_STOP      = 4'h8;
  localparam logic [3:0]  DEST_COAST     = 4'h9;
  localparam logic [3:0]  DEST_FAULT     = 4'hA;
  localparam logic [3:0]  D3_RAMP2_FIRST = 4'h6;
  // interrupt bits
  localparam int          IRQ_STEP       = 0;
  localparam int          IRQ_END        = 1;
  localparam int          IRQ_FAULT      = 2;
  localparam int          IRQ_W          = 3;
  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          TICK_MS        = 100;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic [1:0] {PSS_DIR_FWD, PSS_DIR_REV, PSS_DIR_NONE} pss_dir_t;
  typedef enum logic [1:0] {PSS_IDLE, PSS_RUN} pss_state_t;
endpackage : pss_pkg

// [hw/pss_top.sv]
/*
  Preset step sequencer: eight programmable steps driving frequency command,
  direction, ramp select, one shared output and end/fault actions.
  Assumes a synchronous register port and synchronous drive-side inputs.
*/
// The placing of the registers and the strobed register port were left to the implementer.
// Behaviour
// (R01) program words act only while speed source select equals 6
// (R02) configuring party sets all four digits of each program word
// (R03) configuring party changes program words only while drive stopped
// (R04) advancing may depend on dwell time, logic input, or both
// (R05) logic input a exists for select 23, input b for select 24
// (R06) step dwell used only for condition codes 1, b, C, d, E
// (R07) frequency command equals active step's preset frequency
// (R08) start command starts the sequence at step 0
// (R09) digit 0 condition advances to next step, 7 wraps to 0
// (R10) digit 1 condition (not F) overrides and jumps per digit 2
// (R11) digit 2: 0-7 jump, 8 normal stop, 9 coast, A fault
// (R12) digit 3 picks ramp set and shared output state
// (R13) within each group of three: forward, reverse, no output
// (R14) shared output drives outputs whose select equals 15
// (R15) only one shared output exists for all steps
// (R16) condition codes: skip, dwell, inputs, combinations, dwell plus input, never
// (R17) dwell 0.0 to 999.9 s in 0.1 s units, default 30.0 s
// (R18) dwell timer counts 0.1 s ticks and restarts on step entry
// (R19) logic inputs synchronised, conditions evaluated every clock
`timescale 1ns/1ps
module pss_top
  import pss_pkg::*;
#(
  parameter int TICK_CYC = pss_pkg::TICK_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  input  wire logic                         start_cmd,
  input  wire logic [3:0]                   digital_in,
  output logic      [pss_pkg::FREQ_W-1:0]   freq_cmd,
  output logic      [1:0]                   dir_cmd,
  output logic                              ramp_set2,
  output logic                              run_active,
  output logic                              stop_normal,
  output logic                              stop_coast,
  output logic                              sequence_end_fault,
  output logic      [2:0]                   relay_opto_out,
  output logic                              irq
);
  // ******************************************************************
  // registers
  // ******************************************************************
  logic [15:0]        prog_r  [NUM_STEPS];
  logic [DWELL_W-1:0] dwell_r [NUM_STEPS];
  logic [FREQ_W-1:0]  freq_r  [NUM_STEPS];
  logic [3:0]         speed_source_select_r;
  logic [SEL_W-1:0]   di_sel_r  [4];
  logic [SEL_W-1:0]   out_sel_r [3];
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  pss_state_t         state_r;
  logic [2:0]         step_r;
  logic [DWELL_W-1:0] dwell_cnt_r;
  logic [31:0]        tick_cnt_r;
  logic [3:0]         din_s1_r;
  logic [3:0]         din_s2_r;
  logic               start_d_r;
  logic               shared_r;

  // ******************************************************************
  // decode
  // ******************************************************************
  function automatic logic cond_met(input logic [3:0] c, input logic tdone,
                                    input logic a, input logic b);
    logic r;
    r = 1'b0;
    case (c)
      4'h0: r = 1'b1;
      4'h1: r = tdone;
      4'h2: r = a;
      4'h3: r = b;
      4'h4: r = !a;
      4'h5: r = !b;
      4'h6: r = a | b;
      4'h7: r = a & b;
      4'h8: r = !a & !b;
      4'h9: r = a & !b;
      4'hA: r = b & !a;
      4'hB: r = tdone & a;
      4'hC: r = tdone & b;
      4'hD: r = tdone & !a;
      4'hE: r = tdone & !b;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cond_met

  wire         wr_prog   = reg_wr && reg_addr[7:3] == OFF_PROG_BASE[7:3];
  wire         wr_dwell  = reg_wr && reg_addr[7:3] == OFF_DWELL_BASE[7:3];
  wire         wr_freq   = reg_wr && reg_addr[7:3] == OFF_FREQ_BASE[7:3];
  wire         wr_ctrl   = reg_wr && reg_addr == OFF_CTRL;
  wire         wr_istat  = reg_wr && reg_addr == OFF_IRQ_STAT;
  wire         wr_imask  = reg_wr && reg_addr == OFF_IRQ_MASK;
  wire         wr_osel   = reg_wr && reg_addr == OFF_OUT_SEL;
  wire [2:0]   widx      = reg_addr[2:0];
  // any value above the limit clamps, upper bits included
  wire [DWELL_W-1:0] wdwell = (|reg_wdata[31:DWELL_W] || reg_wdata[DWELL_W-1:0] > DWELL_MAX)
                              ? DWELL_MAX : reg_wdata[DWELL_W-1:0];
  wire         seq_on    = speed_source_select_r == SRC_SEQUENCER;            // see (R01)
  logic        in_a;
  logic        in_b;
  always_comb begin
    in_a = 1'b0;
    in_b = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (di_sel_r[i] == DI_SEL_IN_A) in_a = in_a | din_s2_r[i];              // see (R05)
      if (di_sel_r[i] == DI_SEL_IN_B) in_b = in_b | din_s2_r[i];              // see (R05)
    end
  end
  wire [15:0]  word      = prog_r[step_r];
  wire [3:0]   d0        = word[3:0];
  wire [3:0]   d1        = word[7:4];
  wire [3:0]   d2        = word[11:8];
  wire [3:0]   d3        = word[15:12];
  wire         tdone     = dwell_cnt_r >= dwell_r[step_r];                     // see (R06)
  wire         jump      = d1 != COND_NEVER && cond_met(d1, tdone, in_a, in_b); // see (R10)
  wire         adv       = cond_met(d0, tdone, in_a, in_b);                    // see (R04) (R16)
  wire         start_re  = start_cmd && !start_d_r;
  wire         running   = state_r == PSS_RUN;
  wire         do_jump   = running && jump && d2 <= 4'h7;                       // see (R11)
  wire         do_end    = running && jump && d2 > 4'h7;
  wire         do_adv    = running && !jump && adv;                            // see (R09)
  wire         entering  = (!running && seq_on && start_re) || do_jump || do_adv;
  wire [2:0]   next_step = do_jump ? d2[2:0] : 3'(step_r + 3'h1);
  wire         tick      = tick_cnt_r >= 32'(TICK_CYC - 1);
  wire [IRQ_W-1:0] ev    = {do_end && d2 == DEST_FAULT, do_end, do_jump || do_adv};
  // position within each group of three digit 3 values
  wire [1:0]   sub       = 2'(d3 % 4'h3);
  wire         shared_nx = (d3 >= 4'h3 && d3 <= 4'h5) || (d3 >= 4'h9 && d3 <= 4'hB); // see (R12)
  wire [31:0]  rd_val    =
      (reg_addr[7:3] == OFF_PROG_BASE[7:3])  ? {16'h0000, prog_r[widx]} :
      (reg_addr[7:3] == OFF_DWELL_BASE[7:3]) ? {18'h00000, dwell_r[widx]} :
      (reg_addr[7:3] == OFF_FREQ_BASE[7:3])  ? {16'h0000, freq_r[widx]} :
      (reg_addr == OFF_CTRL) ? {8'h00, di_sel_r[3], di_sel_r[2], di_sel_r[1], di_sel_r[0],
                                speed_source_select_r} :
      (reg_addr == OFF_OUT_SEL) ? {17'h00000, out_sel_r[2], out_sel_r[1], out_sel_r[0]} :
      (reg_addr == OFF_STATUS)   ? {26'h0, in_b, in_a, step_r, running} :
      (reg_addr == OFF_IRQ_STAT) ? {29'h0, irq_stat_r} :
      (reg_addr == OFF_IRQ_MASK) ? {29'h0, irq_mask_r} : 32'h0000_0000;

  // ******************************************************************
  // register file
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        prog_r[i]  <= PROG_RESET;
        dwell_r[i] <= DWELL_RESET;                                             // see (R17)
        freq_r[i]  <= FREQ_RESET;
      end
      speed_source_select_r <= 4'h0;
      for (int i = 0; i < 4; i++) di_sel_r[i] <= 5'h00;
      for (int i = 0; i < 3; i++) out_sel_r[i] <= 5'h00;
      irq_mask_r <= 3'h0;
      reg_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_prog) prog_r[widx] <= reg_wdata[15:0];
      if (wr_dwell) dwell_r[widx] <= wdwell;                                   // see (R17)
      if (wr_freq) freq_r[widx] <= reg_wdata[FREQ_W-1:0];
      if (wr_ctrl) begin
        speed_source_select_r <= reg_wdata[CTRL_SRC_LSB +: 4];
        for (int i = 0; i < 4; i++) di_sel_r[i] <= reg_wdata[CTRL_DI0_LSB + 5*i +: 5];
      end
      if (wr_osel) begin
        for (int i = 0; i < 3; i++) out_sel_r[i] <= reg_wdata[CTRL_RLY_LSB + 5*i +: 5];
      end
      if (wr_imask) irq_mask_r <= reg_wdata[IRQ_W-1:0];
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) irq_stat_r <= 3'h0;
    else irq_stat_r <= (irq_stat_r & ~(wr_istat ? reg_wdata[IRQ_W-1:0] : 3'h0)) | ev;
  end

  // ******************************************************************
  // input synchronisers and tick prescaler
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      din_s1_r  <= 4'h0;
      din_s2_r  <= 4'h0;
      start_d_r <= 1'b0;
    end else begin
      din_s1_r  <= digital_in;                                                 // see (R19)
      din_s2_r  <= din_s1_r;                                                   // see (R19)
      start_d_r <= start_cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || entering) tick_cnt_r <= 32'h0;                                   // see (R18)
    else if (tick) tick_cnt_r <= 32'h0;
    else tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (rst || entering) dwell_cnt_r <= '0;                                     // see (R18)
    else if (tick && dwell_cnt_r != DWELL_MAX) dwell_cnt_r <= 14'(dwell_cnt_r + 14'h1);
  end

  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r            <= PSS_IDLE;
      step_r             <= 3'h0;
      stop_normal        <= 1'b0;
      stop_coast         <= 1'b0;
      sequence_end_fault <= 1'b0;
    end else begin
      stop_normal <= 1'b0;
      stop_coast  <= 1'b0;
      case (state_r)
        PSS_IDLE: begin
          if (seq_on && start_re) begin                                        // see (R01)
            state_r            <= PSS_RUN;
            step_r             <= 3'h0;                                        // see (R08)
            sequence_end_fault <= 1'b0;
          end
        end
        default: begin
          if (!seq_on || !start_cmd) begin
            state_r     <= PSS_IDLE;                                           // see (R01)
            stop_normal <= 1'b1;
          end else if (do_end) begin                                           // see (R11)
            state_r            <= PSS_IDLE;
            stop_normal        <= d2 == DEST_STOP;
            stop_coast         <= d2 == DEST_COAST;
            sequence_end_fault <= d2 == DEST_FAULT;
          end else if (do_jump || do_adv) begin
            step_r <= next_step;                                               // see (R09) (R10)
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_cmd       <= '0;
      dir_cmd        <= PSS_DIR_NONE;
      ramp_set2      <= 1'b0;
      run_active     <= 1'b0;
      shared_r       <= 1'b0;
      relay_opto_out <= 3'h0;
      irq            <= 1'b0;
    end else begin
      run_active <= running;
      freq_cmd   <= running ? freq_r[step_r] : '0;                            // see (R07)
      dir_cmd    <= !running ? PSS_DIR_NONE : (sub == 2'h0) ? PSS_DIR_FWD :
                    (sub == 2'h1) ? PSS_DIR_REV : PSS_DIR_NONE;                // see (R13)
      ramp_set2  <= running && d3 >= D3_RAMP2_FIRST;                           // see (R12)
      shared_r   <= running && shared_nx;                                      // see (R15)
      for (int i = 0; i < 3; i++)
        relay_opto_out[i] <= out_sel_r[i] == OUT_SEL_SHARED && shared_r;       // see (R14)
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule : pss_top

// [testbench/pss_top_sva.sv]
/* Assertions on the preset step sequencer top ports.
   Assumes it is bound to pss_top; one clock, synchronous active-high reset. */
`timescale 1ns/1ps
module pss_top_sva
  import pss_pkg::*;
#(
  parameter int TICK_CYC = 10
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic                       start_cmd,
  input wire logic [3:0]                 digital_in,
  input wire logic [pss_pkg::FREQ_W-1:0] freq_cmd,
  input wire logic [1:0]                 dir_cmd,
  input wire logic                       ramp_set2,
  input wire logic                       run_active,
  input wire logic                       stop_normal,
  input wire logic                       stop_coast,
  input wire logic                       sequence_end_fault,
  input wire logic [2:0]                 relay_opto_out,
  input wire logic                       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ******************************************************************
  // port checks
  // ******************************************************************
  property p_rd_slot; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
  property p_idle_out; !run_active [*2] |-> freq_cmd == '0 && dir_cmd == 2'h2; endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle outputs wrong");
  property p_dir_code; dir_cmd != 2'h3; endproperty
  a_dir_code: assert property (p_dir_code) else $error("bad direction code");
  property p_start_rise; $rose(run_active) |-> start_cmd && $past(start_cmd); endproperty
  a_start_rise: assert property (p_start_rise) else $error("run without start");
  property p_norm_pulse; stop_normal |=> !stop_normal; endproperty
  a_norm_pulse: assert property (p_norm_pulse) else $error("stop pulse too long");
  property p_coast_pulse; stop_coast |=> !stop_coast; endproperty
  a_coast_pulse: assert property (p_coast_pulse) else $error("coast pulse too long");
  property p_stop_mutex; !(stop_normal && stop_coast); endproperty
  a_stop_mutex: assert property (p_stop_mutex) else $error("two stop kinds");
  property p_stop_ends; stop_normal || stop_coast |-> ##[0:2] !run_active; endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("run kept after stop");
  property p_fault_ends; $rose(sequence_end_fault) |-> ##[0:2] !run_active; endproperty
  a_fault_ends: assert property (p_fault_ends) else $error("run kept after fault");
  property p_fault_hold; sequence_end_fault && !start_cmd |=> sequence_end_fault; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");
  property p_drop_stop; run_active && $fell(start_cmd) |-> ##[0:3] stop_normal; endproperty
  a_drop_stop: assert property (p_drop_stop) else $error("no stop on drop");
endmodule : pss_top_sva

bind pss_top pss_top_sva #(.TICK_CYC(TICK_CYC)) u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_cmd(start_cmd), .digital_in(digital_in),
  .freq_cmd(freq_cmd), .dir_cmd(dir_cmd), .ramp_set2(ramp_set2), .run_active(run_active),
  .stop_normal(stop_normal), .stop_coast(stop_coast), .irq(irq),
  .sequence_end_fault(sequence_end_fault), .relay_opto_out(relay_opto_out));

// [testbench/pss_drive_model.sv]
/* Drive-side partner: start command, digital input pins, stop pulse counters.
   Assumes requests from the bench; unused pins carry changing noise. */
`timescale 1ns/1ps
module pss_drive_model (
  input  wire logic       clk,
  input  wire logic       run_req,
  input  wire logic       in_a,
  input  wire logic       in_b,
  input  wire logic       stop_normal,
  input  wire logic       stop_coast,
  output logic            start_cmd = 1'b0,
  output logic [3:0]      digital_in = 4'h0,
  output logic [7:0]      normal_cnt = 8'h00,
  output logic [7:0]      coast_cnt = 8'h00
);
  always @(posedge clk) begin
    start_cmd  <= run_req;
    digital_in <= {~digital_in[3], in_b, ~digital_in[1], in_a};
    normal_cnt <= normal_cnt + {7'h00, stop_normal};
    coast_cnt  <= coast_cnt + {7'h00, stop_coast};
  end
endmodule : pss_drive_model

// [testbench/pss_top_tb.sv]
/* Self-checking bench for the preset step sequencer.
   Assumes pss_top, the drive partner model and the bound checker. */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module pss_top_tb;
  import pss_pkg::*;
  localparam int          TICK   = 10;
  localparam logic [31:0] CTRL_V = 32'h0F061F76;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        run_req = 1'b0, in_a = 1'b0, in_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        start_cmd, ramp_set2, run_active, stop_normal, stop_coast, fault, irq;
  logic [3:0]  digital_in;
  logic [15:0] freq_cmd, fq [8];
  logic [1:0]  dir_cmd;
  logic [2:0]  relay_opto_out;
  logic [7:0]  normal_cnt, coast_cnt, n0, c0;
  int          errors = 0, tests_run = 0, cyc = 0, seed = 32'hEDE347D4;
  // ******************************************************************
  // design, partner and reference helpers
  // ******************************************************************
  pss_top #(.TICK_CYC(TICK)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .start_cmd(start_cmd), .digital_in(digital_in), .freq_cmd(freq_cmd), .dir_cmd(dir_cmd),
    .ramp_set2(ramp_set2), .run_active(run_active), .stop_normal(stop_normal),
    .stop_coast(stop_coast), .sequence_end_fault(fault), .relay_opto_out(relay_opto_out),
    .irq(irq));
  pss_drive_model u_drive (.clk(clk), .run_req(run_req), .in_a(in_a), .in_b(in_b),
    .stop_normal(stop_normal), .stop_coast(stop_coast), .start_cmd(start_cmd),
    .digital_in(digital_in), .normal_cnt(normal_cnt), .coast_cnt(coast_cnt));
  always #5 clk = ~clk;
  function automatic bit cond_true(input logic [3:0] c, input bit a, input bit b);
    case (c)
      4'h0, 4'h1: return 1'b1;
      4'h2, 4'hB: return a;
      4'h3, 4'hC: return b;
      4'h4, 4'hD: return !a;
      4'h5, 4'hE: return !b;
      4'h6: return a | b;
      4'h7: return a & b;
      4'h8: return !a & !b;
      4'h9: return a & !b;
      4'hA: return b & !a;
      default: return 1'b0;
    endcase
  endfunction : cond_true
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask : rd
  task automatic go(input int n);
    @(posedge clk);
    run_req <= 1'b1;
    repeat (n) @(posedge clk);
    #1;
  endtask : go
  task automatic halt();
    @(posedge clk);
    run_req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : halt
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end
  // ******************************************************************
  // scenarios
  // ******************************************************************
  initial begin
    for (int i = 0; i < 8; i++) fq[i] = {4'(i + 1), 12'($random(seed))};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(OFF_PROG_BASE + 8'(i), 32'h00F1);
    rd(OFF_DWELL_BASE, 32'h012C);
    rd(8'h1F, 32'h0);
    `CHK("dir_cmd", 2'h2, dir_cmd)
    for (int i = 0; i < 8; i++) wr(OFF_FREQ_BASE + 8'(i), {16'h0, fq[i]});
    wr(OFF_DWELL_BASE, 32'h0);
    wr(OFF_DWELL_BASE + 8'h1, 32'hFFFF);
    rd(OFF_DWELL_BASE + 8'h1, 32'h270F);
    wr(OFF_CTRL, CTRL_V & 32'hFFFFFFF0);
    go(8);
    `CHK("run_active", 1'b0, run_active)
    halt();
    wr(OFF_CTRL, CTRL_V);
    wr(OFF_OUT_SEL, 32'h01EF);
    rd(OFF_CTRL, CTRL_V & 32'h00FFFFFF);
    rd(OFF_OUT_SEL, 32'h01EF);
    for (int k = 0; k < 12; k++) begin
      wr(OFF_PROG_BASE, {16'h0, k[3:0], 12'h0FF});
      go(6);
      `CHK("dir_cmd", 2'(k % 3), dir_cmd)
      `CHK("ramp_set2", k >= 6, ramp_set2)
      `CHK("relay_opto_out", ((k % 6) >= 3) ? 3'h3 : 3'h0, relay_opto_out)
      `CHK("freq_cmd", fq[0], freq_cmd)
      halt();
    end
    for (int i = 1; i < 8; i++) wr(OFF_PROG_BASE + 8'(i), 32'h00FF);
    for (int c = 0; c < 16; c++) begin
      for (int ab = 0; ab < 4; ab++) begin
        in_a <= ab[0];
        in_b <= ab[1];
        wr(OFF_PROG_BASE, {28'h000000F, c[3:0]});
        go(8);
        `CHK("freq_cmd", fq[cond_true(c[3:0], ab[0], ab[1])], freq_cmd)
        halt();
      end
    end
    for (int d = 0; d < 11; d++) begin
      wr(OFF_PROG_BASE, {20'h0, d[3:0], 8'h00});
      n0 = normal_cnt;
      c0 = coast_cnt;
      go(8);
      if (d < 8) `CHK("freq_cmd", fq[d], freq_cmd)
      else `CHK("run_active", 1'b0, run_active)
      `CHK("stop_normal", d == 8, normal_cnt - n0)
      `CHK("stop_coast", d == 9, coast_cnt - c0)
      `CHK("sequence_end_fault", d == 10, fault)
      halt();
    end
    wr(OFF_PROG_BASE, 32'h073F);
    wr(OFF_PROG_BASE + 8'h7, 32'h00F2);
    in_a <= 1'b0;
    in_b <= 1'b1;
    go(8);
    `CHK("freq_cmd", fq[7], freq_cmd)
    `CHK("sequence_end_fault", 1'b0, fault)
    rd(OFF_STATUS, 32'h2F);
    @(posedge clk);
    in_a <= 1'b1;
    in_b <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK("freq_cmd", fq[0], freq_cmd)
    halt();
    wr(OFF_PROG_BASE, 32'h00F1);
    wr(OFF_DWELL_BASE, 32'h3);
    go(20);
    `CHK("freq_cmd", fq[0], freq_cmd)
    repeat (25) @(posedge clk);
    #1;
    `CHK("freq_cmd", fq[1], freq_cmd)
    halt();
    `CHK("irq", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h7);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wr(OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rd(OFF_IRQ_MASK, 32'h7);
    go(6);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("run_active", 1'b0, run_active)
    `CHK("dir_cmd", 2'h2, dir_cmd)
    rd(OFF_PROG_BASE, 32'h00F1);
    halt();
    conclude();
  end
endmodule : pss_top_tb
